// ===== hdl/reset_watchdog_pkg.sv
// Constants and types shared by the reset controller and its watchdog counter.
package reset_watchdog_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register addresses on the plain register port.
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OPTIONS = 8'h01;

  // Field positions of the reset status register.
  localparam int unsigned ST_POR  = 7;
  localparam int unsigned ST_PIN  = 6;
  localparam int unsigned ST_WDOG = 5;
  localparam int unsigned ST_ILOP = 4;
  localparam int unsigned ST_ILAD = 3;
  localparam int unsigned ST_LVD  = 1;

  // Field positions of the system options register.
  localparam int unsigned OPT_EN     = 7;
  localparam int unsigned OPT_PERIOD = 6;

  localparam logic [DATA_W-1:0] OPTIONS_RESET    = 8'hc0;
  localparam logic [DATA_W-1:0] OPTIONS_MASK     = 8'hc0;
  localparam logic [DATA_W-1:0] STATUS_POR_VALUE = 8'h80;
  localparam logic [DATA_W-1:0] DATA_ZERO        = 8'h00;

  // Reset pin timing in bus-rate cycles.
  localparam int unsigned       SEQ_W                 = 6;
  localparam logic [SEQ_W-1:0]  PIN_DRIVE_BUS_CYCLES  = 6'h22;
  localparam logic [SEQ_W-1:0]  PIN_SAMPLE_BUS_CYCLES = 6'h26;
  localparam logic [SEQ_W-1:0]  SEQ_ONE               = 6'h01;
  localparam logic [SEQ_W-1:0]  SEQ_ZERO              = 6'h00;

  // Watchdog periods as powers of two of bus-rate cycles.
  localparam int unsigned WDOG_SHORT_EXP = 18;
  localparam int unsigned WDOG_LONG_EXP  = 20;
  localparam int unsigned WDOG_W         = 21;

  typedef enum logic [1:0] {
    SEQ_RUN,
    SEQ_DRIVE,
    SEQ_SETTLE,
    SEQ_HOLD
  } seq_state_t;

endpackage

// ===== hdl/watchdog_link_if.sv
// Signals between the reset sequencer and the watchdog counter.
`timescale 1ns/100ps
`default_nettype none
interface watchdog_link_if;
  logic tick;
  logic run;
  logic clear;
  logic period_long;
  logic timeout;

  modport ctrl (
    output tick,
    output run,
    output clear,
    output period_long,
    input  timeout
  );

  modport counter (
    input  tick,
    input  run,
    input  clear,
    input  period_long,
    output timeout
  );
endinterface
`default_nettype wire

// ===== hdl/watchdog_counter.sv
// Bus-rate watchdog counter with two selectable timeout periods.
`timescale 1ns/100ps
`default_nettype none
module watchdog_counter
  import reset_watchdog_pkg::*;
#(
  parameter int unsigned SHORT_CYCLES = 2**WDOG_SHORT_EXP,
  parameter int unsigned LONG_CYCLES  = 2**WDOG_LONG_EXP
) (
  input  wire logic       i_sys_clk,  // System clock.
  input  wire logic       i_srst,     // Synchronous reset, active high.
  input  wire logic       i_clk_en,   // Clock enable, freezes state when low.
  watchdog_link_if.counter link       // Control and timeout.
);

  localparam logic [WDOG_W-1:0] SHORT_LAST = WDOG_W'(SHORT_CYCLES - 1);
  localparam logic [WDOG_W-1:0] LONG_LAST  = WDOG_W'(LONG_CYCLES - 1);
  localparam logic [WDOG_W-1:0] CNT_ZERO   = '0;
  localparam logic [WDOG_W-1:0] CNT_ONE    = WDOG_W'(1);

  logic [WDOG_W-1:0] count;
  logic [WDOG_W-1:0] last;
  logic              timeout;

  assign last         = link.period_long ? LONG_LAST : SHORT_LAST;
  assign link.timeout = timeout;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      count <= CNT_ZERO;
    end else if (i_clk_en) begin
      if (link.clear) begin
        count <= CNT_ZERO;
      end else if (link.run && link.tick) begin
        if (count == last) begin
          count <= CNT_ZERO;
        end else begin
          count <= count + CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      timeout <= 1'b0;
    end else if (i_clk_en) begin
      timeout <= !link.clear && link.run && link.tick && (count == last);
    end
  end

  service_clears_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && link.clear) |=> (count == CNT_ZERO)
  ) else $error("watchdog count not zero after a service clear");

  hold_when_stopped_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    (!link.run && !link.clear) |=> $stable(count)
  ) else $error("watchdog count moved while the watchdog was stopped");

endmodule
`default_nettype wire

// ===== hdl/reset_control_with_watchdog.sv
// System reset controller with reset pin sequencing and an operating watchdog.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module reset_control_with_watchdog
  import reset_watchdog_pkg::*;
#(
  parameter bit          HAS_ILLEGAL_ADDR  = 1'b1,
  parameter int unsigned WDOG_SHORT_CYCLES = 2**WDOG_SHORT_EXP,
  parameter int unsigned WDOG_LONG_CYCLES  = 2**WDOG_LONG_EXP
) (
  input  wire logic              i_sys_clk,            // Oscillator clock, 100 MHz.
  input  wire logic              i_srst,               // Power-on reset, synchronous, active high.
  input  wire logic              i_clk_en,             // Clock enable.
  input  wire logic [ADDR_W-1:0] i_addr,               // Register address.
  input  wire logic [DATA_W-1:0] i_wdata,              // Register write data.
  input  wire logic              i_wr,                 // Write strobe.
  input  wire logic              i_rd,                 // Read strobe.
  output      logic [DATA_W-1:0] o_rdata,              // Read data, cycle after strobe.
  input  wire logic              i_low_voltage_detect, // Low-voltage reset request.
  input  wire logic              i_illegal_opcode,     // Illegal opcode reset request.
  input  wire logic              i_illegal_address,    // Illegal address reset request.
  input  wire logic              i_debug_force_reset,  // Debug-forced reset request.
  input  wire logic              i_active_background,  // Processor in background debug mode.
  input  wire logic              i_reset_pin,          // Reset pin level, asynchronous.
  output      logic              o_reset_pin,          // Reset pin drive level.
  output      logic              o_reset_pin_oe_n,     // Reset pin drive enable, low drives.
  output      logic              o_system_reset,       // Chip held in reset.
  output      logic              o_watchdog_running    // Watchdog counting.
);

  seq_state_t        state;
  logic [SEQ_W-1:0]  seq_count;
  logic              bus_phase;
  logic              bus_tick;
  logic              pin_meta;
  logic              pin_sync;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] options;
  logic              options_locked;
  logic              status_write;
  logic              options_write;
  logic              illegal_addr_req;
  logic              any_request;
  logic [DATA_W-1:0] next_causes;
  logic              watchdog_run;

  watchdog_link_if wdog ();

  // Bus-rate strobe: one oscillator cycle in two.
  // A new reset restarts the phase so the pin drive always spans whole bus cycles.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      bus_phase <= 1'b0;
    end else if (i_clk_en) begin
      if (state == SEQ_RUN && any_request) begin
        bus_phase <= 1'b0;
      end else begin
        bus_phase <= !bus_phase;
      end
    end
  end

  assign bus_tick = bus_phase && i_clk_en;

  // The pin is asynchronous to the oscillator clock.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else if (i_clk_en) begin
      pin_meta <= i_reset_pin;
      pin_sync <= pin_meta;
    end
  end

  assign status_write     = i_wr && (i_addr == ADDR_STATUS);
  assign options_write    = i_wr && (i_addr == ADDR_OPTIONS);
  assign illegal_addr_req = HAS_ILLEGAL_ADDR && i_illegal_address;

  // Requests seen while the chip runs, and the flags they load.
  always_comb begin
    next_causes          = DATA_ZERO;
    next_causes[ST_LVD]  = i_low_voltage_detect;
    next_causes[ST_WDOG] = wdog.timeout;
    next_causes[ST_ILOP] = i_illegal_opcode;
    next_causes[ST_ILAD] = illegal_addr_req;
    any_request = i_low_voltage_detect || wdog.timeout || i_illegal_opcode
               || illegal_addr_req || i_debug_force_reset || !pin_sync;
  end

  // Reset sequencer: drive the pin, let it settle, sample it.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state     <= SEQ_DRIVE;
      seq_count <= SEQ_ZERO;
    end else if (i_clk_en) begin
      case (state)
        SEQ_RUN: begin
          if (any_request) begin
            state     <= SEQ_DRIVE;
            seq_count <= SEQ_ZERO;
          end
        end
        SEQ_DRIVE: begin
          if (bus_tick) begin
            if (seq_count == PIN_DRIVE_BUS_CYCLES - SEQ_ONE) begin
              state     <= SEQ_SETTLE;
              seq_count <= SEQ_ZERO;
            end else begin
              seq_count <= seq_count + SEQ_ONE;
            end
          end
        end
        SEQ_SETTLE: begin
          if (bus_tick) begin
            if (seq_count == PIN_SAMPLE_BUS_CYCLES - SEQ_ONE) begin
              state     <= pin_sync ? SEQ_RUN : SEQ_HOLD;
              seq_count <= SEQ_ZERO;
            end else begin
              seq_count <= seq_count + SEQ_ONE;
            end
          end
        end
        SEQ_HOLD: begin
          if (pin_sync) begin
            state <= SEQ_RUN;
          end
        end
        default: begin
          state     <= SEQ_DRIVE;
          seq_count <= SEQ_ZERO;
        end
      endcase
    end
  end

  // Pin drive follows the sequencer one cycle later, from flip-flops.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_reset_pin      <= 1'b0;
      o_reset_pin_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      o_reset_pin      <= 1'b0;
      o_reset_pin_oe_n <= (state != SEQ_DRIVE);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_system_reset <= 1'b1;
    end else if (i_clk_en) begin
      o_system_reset <= (state != SEQ_RUN);
    end
  end

  // Reset status register: loaded on reset entry, never by a bus write.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      status <= STATUS_POR_VALUE;
    end else if (i_clk_en) begin
      if (state == SEQ_RUN && any_request) begin
        status <= next_causes;
      end else if (state == SEQ_SETTLE && bus_tick
                   && seq_count == PIN_SAMPLE_BUS_CYCLES - SEQ_ONE && !pin_sync) begin
        status[ST_PIN] <= 1'b1;
      end
    end
  end

  // System options register: one write after each reset.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      options        <= OPTIONS_RESET;
      options_locked <= 1'b0;
    end else if (i_clk_en) begin
      if (state != SEQ_RUN) begin
        options        <= OPTIONS_RESET;
        options_locked <= 1'b0;
      end else if (options_write && !options_locked) begin
        options        <= i_wdata & OPTIONS_MASK;
        options_locked <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rdata <= DATA_ZERO;
    end else if (i_clk_en) begin
      if (i_rd && i_addr == ADDR_STATUS) begin
        o_rdata <= status;
      end else if (i_rd && i_addr == ADDR_OPTIONS) begin
        o_rdata <= options;
      end else begin
        o_rdata <= DATA_ZERO;
      end
    end
  end

  // Watchdog control.
  assign watchdog_run = options[OPT_EN] && !i_active_background
                     && (state == SEQ_RUN);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_watchdog_running <= 1'b0;
    end else if (i_clk_en) begin
      o_watchdog_running <= watchdog_run;
    end
  end

  assign wdog.tick        = bus_tick;
  assign wdog.run         = watchdog_run;
  assign wdog.clear       = status_write || (state != SEQ_RUN);
  assign wdog.period_long = options[OPT_PERIOD];

  watchdog_counter #(
    .SHORT_CYCLES (WDOG_SHORT_CYCLES),
    .LONG_CYCLES  (WDOG_LONG_CYCLES)
  ) u_watchdog_counter (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_clk_en  (i_clk_en),
    .link      (wdog.counter)
  );

  // Helper counters of bus cycles spent driving and settling.
  logic [SEQ_W-1:0] drive_ticks;
  logic [SEQ_W-1:0] settle_ticks;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      drive_ticks  <= SEQ_ZERO;
      settle_ticks <= SEQ_ZERO;
    end else begin
      if (state == SEQ_RUN) begin
        drive_ticks <= SEQ_ZERO;
      end else if (state == SEQ_DRIVE && bus_tick) begin
        drive_ticks <= drive_ticks + SEQ_ONE;
      end
      if (state != SEQ_SETTLE) begin
        settle_ticks <= SEQ_ZERO;
      end else if (bus_tick) begin
        settle_ticks <= settle_ticks + SEQ_ONE;
      end
    end
  end

  sequence drive_done_s;
    (state == SEQ_DRIVE) ##1 (state == SEQ_SETTLE);
  endsequence

  sequence settle_done_s;
    (state == SEQ_SETTLE) ##1 (state != SEQ_SETTLE);
  endsequence

  drive_span_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    drive_done_s |-> (drive_ticks == PIN_DRIVE_BUS_CYCLES) ##1 $rose(o_reset_pin_oe_n)
  ) else $error("reset pin not driven for the full bus-cycle count");

  settle_span_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    settle_done_s |-> (settle_ticks == PIN_SAMPLE_BUS_CYCLES)
  ) else $error("reset pin sampled at the wrong bus cycle");

  pin_sample_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    (state == SEQ_SETTLE) ##1 (state == SEQ_HOLD) |-> status[ST_PIN]
  ) else $error("low pin at sample time not recorded as cause");

  bus_rate_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    bus_tick |=> !bus_tick
  ) else $error("bus-rate strobe faster than half the clock");

  no_illegal_addr_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    !HAS_ILLEGAL_ADDR |-> !status[ST_ILAD]
  ) else $error("illegal address flag set in a variant without it");

  watchdog_reset_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && wdog.timeout && state == SEQ_RUN)
      |=> (state == SEQ_DRIVE) && status[ST_WDOG] ##1 !o_reset_pin_oe_n
  ) else $error("watchdog timeout did not start a reset");

  service_keeps_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && status_write && state == SEQ_RUN && !any_request) |=> $stable(status)
  ) else $error("service write changed the reset status register");

  enabled_after_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    $fell(o_system_reset) |-> options[OPT_EN] && !options_locked
  ) else $error("watchdog not enabled when leaving reset");

  write_once_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    (options_locked && state == SEQ_RUN) |=> $stable(options)
  ) else $error("options register changed after it was locked");

  debug_suspend_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && i_active_background) |=> !o_watchdog_running
  ) else $error("watchdog running in background debug mode");

  disabled_stop_a: assert property (
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && !options[OPT_EN]) |=> !o_watchdog_running
  ) else $error("watchdog running with its enable bit clear");

endmodule
`default_nettype wire

// ===== testbench/reset_pin_model.sv
// Reset pin wire with its pull-up and an outside party that may hold it low.
`timescale 1ns/100ps
`default_nettype none
module reset_pin_model (
  input  wire logic i_drive_level, // Level the device puts on the pin.
  input  wire logic i_drive_oe_n,  // Device drives the pin while low.
  input  wire logic i_hold_low,    // Outside circuit pulls the pin low.
  output wire logic o_pin          // Resolved pin level.
);
  // A released pin floats up through the pull-up unless held from outside.
  assign o_pin = i_hold_low ? 1'b0 : (i_drive_oe_n ? 1'b1 : i_drive_level);
endmodule
`default_nettype wire

// ===== testbench/reset_control_with_watchdog_test.sv
// Self-checking testbench for the reset controller and its watchdog.
`timescale 1ns/100ps
`default_nettype none
module reset_control_with_watchdog_test;
  import reset_watchdog_pkg::*;
  logic              sys_clk;
  logic              srst;
  logic              clk_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic [2:0]        src;
  logic              dbg_rst;
  logic              bgnd;
  logic              hold_low;
  wire logic         pin;
  wire logic         pin_na;
  logic              pin_out;
  logic              oe_n;
  logic              sys_rst;
  logic              wd_run;
  logic              pin_out_na;
  logic              oe_n_na;
  logic              sys_rst_na;
  int                n_mismatch;
  int                compares;
  int                n;
  int                bits [3];
  logic [DATA_W-1:0] d;

  reset_control_with_watchdog #(.WDOG_SHORT_CYCLES(64), .WDOG_LONG_CYCLES(256)) dut (
    .i_sys_clk(sys_clk), .i_srst(srst), .i_clk_en(clk_en), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_low_voltage_detect(src[1]),
    .i_illegal_opcode(src[2]), .i_illegal_address(src[0]), .i_debug_force_reset(dbg_rst),
    .i_active_background(bgnd), .i_reset_pin(pin), .o_reset_pin(pin_out),
    .o_reset_pin_oe_n(oe_n), .o_system_reset(sys_rst), .o_watchdog_running(wd_run));

  // Same stimulus, built without the illegal-address source.
  reset_control_with_watchdog #(.HAS_ILLEGAL_ADDR(1'b0), .WDOG_SHORT_CYCLES(64),
    .WDOG_LONG_CYCLES(256)) dut_na (
    .i_sys_clk(sys_clk), .i_srst(srst), .i_clk_en(clk_en), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(), .i_low_voltage_detect(src[1]),
    .i_illegal_opcode(src[2]), .i_illegal_address(src[0]), .i_debug_force_reset(dbg_rst),
    .i_active_background(bgnd), .i_reset_pin(pin_na), .o_reset_pin(pin_out_na),
    .o_reset_pin_oe_n(oe_n_na), .o_system_reset(sys_rst_na), .o_watchdog_running());

  reset_pin_model pin_main (.i_drive_level(pin_out), .i_drive_oe_n(oe_n),
    .i_hold_low(hold_low), .o_pin(pin));
  reset_pin_model pin_second (.i_drive_level(pin_out_na), .i_drive_oe_n(oe_n_na),
    .i_hold_low(hold_low), .o_pin(pin_na));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t: data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_count(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("CHECK FAILED %0t: %0d cycles, expected %0d to %0d", $time, got, lo, hi);
    end
  endtask

  function automatic logic pick(input int which);
    return (which == 0) ? oe_n : sys_rst;
  endfunction

  // Counts clock cycles until the chosen output reaches the given level.
  task automatic wait_for(input int which, input logic val, input int lim, output int cnt);
    cnt = 0;
    while (pick(which) !== val) begin
      @(posedge sys_clk);
      #1;
      cnt++;
      if (cnt > lim) begin
        n_mismatch++;
        $display("CHECK FAILED %0t: wait ran out", $time);
        close_out();
      end
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic read_expect(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    rd_reg(a, d);
    chk_data(d, exp);
  endtask

  task automatic reset_cycle();
    wait_for(1, 1'b1, 20, n);
    wait_for(1, 1'b0, 400, n);
  endtask

  initial begin
    srst = 1'b1; clk_en = 1'b1; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0;
    src = 3'h0; dbg_rst = 1'b0; bgnd = 1'b0; hold_low = 1'b0;
    n_mismatch = 0; compares = 0;
    bits = '{ST_ILAD, ST_LVD, ST_ILOP};
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    wait_for(0, 1'b0, 10, n);
    chk_flag(pin, 1'b0);
    wait_for(0, 1'b1, 200, n);
    chk_count(n, 68, 68);
    wait_for(1, 1'b0, 200, n);
    chk_count(n, 76, 79);
    read_expect(ADDR_STATUS, STATUS_POR_VALUE);
    read_expect(ADDR_OPTIONS, OPTIONS_RESET);
    chk_flag(wd_run, 1'b1);
    read_expect(8'h7f, DATA_ZERO);
    wr_reg(8'h7f, 8'hff);
    wr_reg(ADDR_STATUS, 8'hff);
    read_expect(ADDR_STATUS, STATUS_POR_VALUE);
    // Three internal sources in turn, illegal address first, which the build without it ignores.
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      src <= 3'h1 << k;
      @(posedge sys_clk);
      src <= 3'h0;
      #1;
      wait_for(1, 1'b1, 20, n);
      if (k == 0) begin
        chk_flag(sys_rst_na, 1'b0);
      end
      wait_for(0, 1'b1, 200, n);
      chk_count(n, 68, 68);
      wait_for(1, 1'b0, 400, n);
      read_expect(ADDR_STATUS, 8'h01 << bits[k]);
    end
    @(posedge sys_clk);
    dbg_rst <= 1'b1;
    @(posedge sys_clk);
    dbg_rst <= 1'b0;
    #1;
    reset_cycle();
    read_expect(ADDR_STATUS, DATA_ZERO);
    // The outside party holds the pin low through the whole sequence.
    @(posedge sys_clk);
    hold_low <= 1'b1;
    wait_for(1, 1'b1, 20, n);
    wait_for(0, 1'b1, 200, n);
    repeat (100) @(posedge sys_clk);
    hold_low <= 1'b0;
    #1;
    wait_for(1, 1'b0, 400, n);
    read_expect(ADDR_STATUS, 8'h01 << ST_PIN);
    wr_reg(ADDR_OPTIONS, 8'h80);
    wr_reg(ADDR_STATUS, 8'h00);
    wait_for(1, 1'b1, 300, n);
    chk_count(n, 126, 136);
    wait_for(1, 1'b0, 400, n);
    read_expect(ADDR_STATUS, 8'h01 << ST_WDOG);
    read_expect(ADDR_OPTIONS, OPTIONS_RESET);
    wr_reg(ADDR_STATUS, 8'h00);
    wait_for(1, 1'b1, 700, n);
    chk_count(n, 510, 520);
    wait_for(1, 1'b0, 400, n);
    for (int k = 0; k < 3; k++) begin
      repeat (400) @(posedge sys_clk);
      wr_reg(ADDR_STATUS, 8'h3c);
      chk_flag(sys_rst, 1'b0);
    end
    read_expect(ADDR_STATUS, 8'h01 << ST_WDOG);
    wr_reg(ADDR_OPTIONS, 8'h80);
    wr_reg(ADDR_STATUS, 8'h00);
    @(posedge sys_clk);
    bgnd <= 1'b1;
    repeat (300) @(posedge sys_clk);
    #1;
    chk_flag(sys_rst, 1'b0);
    @(posedge sys_clk);
    bgnd <= 1'b0;
    #1;
    wait_for(1, 1'b1, 160, n);
    chk_count(n, 2, 136);
    wait_for(1, 1'b0, 400, n);
    wr_reg(ADDR_OPTIONS, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1;
    chk_flag(wd_run, 1'b0);
    wr_reg(ADDR_OPTIONS, OPTIONS_RESET);
    read_expect(ADDR_OPTIONS, DATA_ZERO);
    repeat (600) @(posedge sys_clk);
    #1;
    chk_flag(sys_rst, 1'b0);
    @(posedge sys_clk);
    dbg_rst <= 1'b1;
    @(posedge sys_clk);
    dbg_rst <= 1'b0;
    #1;
    // A low clock enable freezes the sequence with the pin still driven.
    wait_for(1, 1'b1, 20, n);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (100) @(posedge sys_clk);
    clk_en <= 1'b1;
    #1;
    chk_flag(oe_n, 1'b0);
    chk_flag(sys_rst, 1'b1);
    wait_for(1, 1'b0, 400, n);
    chk_count(n, 141, 145);
    read_expect(ADDR_OPTIONS, OPTIONS_RESET);
    chk_flag(wd_run, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
